// >>> rtl/hst_tx_top.sv
// hd link transmit formatter: trs, line number and crc insertion, interleave, scramble, nrzi
`timescale 1ns/1ns

module hst_tx_top
	import hst_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST,
	// parallel video source, one sample per handshake
	input wire hst_sample_t VID_IN,
	input wire logic VID_VALID,
	output logic VID_READY,
	// serializer side, 20 bits per cycle
	output logic [PAR_W-1:0] TX_DATA,
	output logic TX_VALID,
	input wire logic TX_READY
);

	// =====================================================
	// crc over one 10-bit word, lsb first, reflected register
	function automatic logic [CRC_W-1:0] crc_word(
		input logic [CRC_W-1:0] crc_in,
		input logic [WORD_W-1:0] d
	);
		logic [CRC_W-1:0] c;
		logic fb;
		c = crc_in;
		fb = 1'b0;
		for (int i = 0; i < WORD_W; i++)
		begin
			fb = d[i] ^ c[0];
			c = {fb, c[CRC_W-1:1]};
			c[12] = c[12] ^ fb; // x^5 tap
			c[13] = c[13] ^ fb; // x^4 tap
		end
		return c;
	endfunction : crc_word

	// keep source data out of the reserved preamble codes
	function automatic logic [WORD_W-1:0] clip_word(input logic [WORD_W-1:0] d);
		if (d >= CLIP_HI_LIM)
			return CLIP_HI_VAL;
		else if (d <= CLIP_LO_LIM)
			return CLIP_LO_VAL;
		else
			return d;
	endfunction : clip_word

	// =====================================================
	// formatter state
	hst_state_t state_reg;
	hst_state_t state_next;
	logic is_eav_reg;
	logic field_reg;
	logic vblank_reg;
	logic in_active_reg;
	logic [LINE_W-1:0] line_reg;
	logic [CRC_W-1:0] crc_c_reg;
	logic [CRC_W-1:0] crc_y_reg;

	// =====================================================
	// named decode wires
	logic fire;
	logic trs_start;
	logic start_eav;
	logic cur_eav;
	logic cur_f;
	logic cur_v;
	logic [WORD_W-1:0] flags_word;
	logic [WORD_W-1:0] ln_word0;
	logic [WORD_W-1:0] ln_word1;
	logic [WORD_W-1:0] crc_c_w0;
	logic [WORD_W-1:0] crc_c_w1;
	logic [WORD_W-1:0] crc_y_w0;
	logic [WORD_W-1:0] crc_y_w1;
	logic crc_take;
	logic crc_clear;
	hst_pair_t fmt_pair;
	logic fifo_in_ready;

	assign fire = VID_VALID && fifo_in_ready;
	assign VID_READY = fifo_in_ready;
	assign trs_start = (state_reg == S_PASS) && (VID_IN.eav_start || VID_IN.sav_start);
	assign start_eav = VID_IN.eav_start;

	// flags for the word being built: latched values after the first slot
	assign cur_eav = (state_reg == S_PASS) ? start_eav : is_eav_reg;
	assign cur_f = field_reg;
	assign cur_v = vblank_reg;

	// flags word with protection bits
	assign flags_word = {1'b1, cur_f, cur_v, cur_eav,
		cur_v ^ cur_eav, cur_f ^ cur_eav, cur_f ^ cur_v,
		cur_f ^ cur_v ^ cur_eav, 2'b00};

	// line number words, same value in both channels
	assign ln_word0 = {~line_reg[6], line_reg[6:0], 2'b00};
	assign ln_word1 = {1'b1, 3'b000, line_reg[10:7], 2'b00};

	// crc words: low nine bits then high nine bits
	assign crc_c_w0 = {~crc_c_reg[8], crc_c_reg[8:0]};
	assign crc_c_w1 = {~crc_c_reg[17], crc_c_reg[17:9]};
	assign crc_y_w0 = {~crc_y_reg[8], crc_y_reg[8:0]};
	assign crc_y_w1 = {~crc_y_reg[17], crc_y_reg[17:9]};

	// crc takes active words, eav words and line number words only
	assign crc_take = fire && in_active_reg && (state_reg != S_CRC0)
		&& (state_reg != S_CRC1);
	assign crc_clear = fire && (state_reg == S_TRS3) && !is_eav_reg;

	// =====================================================
	// per-slot word selection, both channels
	always_comb
	begin
		fmt_pair = '0;
		case (state_reg)
			S_PASS:
			begin
				if (trs_start)
				begin
					fmt_pair.c_word = TRS_ONES;
					fmt_pair.y_word = TRS_ONES;
				end
				else
				begin
					fmt_pair.c_word = clip_word(VID_IN.c_word);
					fmt_pair.y_word = clip_word(VID_IN.y_word);
				end
			end
			S_TRS1, S_TRS2:
			begin
				fmt_pair.c_word = TRS_ZERO;
				fmt_pair.y_word = TRS_ZERO;
			end
			S_TRS3:
			begin
				fmt_pair.c_word = flags_word;
				fmt_pair.y_word = flags_word;
			end
			S_LN0:
			begin
				fmt_pair.c_word = ln_word0;
				fmt_pair.y_word = ln_word0;
			end
			S_LN1:
			begin
				fmt_pair.c_word = ln_word1;
				fmt_pair.y_word = ln_word1;
			end
			S_CRC0:
			begin
				fmt_pair.c_word = crc_c_w0;
				fmt_pair.y_word = crc_y_w0;
			end
			S_CRC1:
			begin
				fmt_pair.c_word = crc_c_w1;
				fmt_pair.y_word = crc_y_w1;
			end
			default:
			begin
				fmt_pair = '0;
			end
		endcase
	end

	// slot sequence: eav is 4 trs + 2 line + 2 crc slots, sav is 4 trs slots
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			S_PASS: state_next = trs_start ? S_TRS1 : S_PASS;
			S_TRS1: state_next = S_TRS2;
			S_TRS2: state_next = S_TRS3;
			S_TRS3: state_next = is_eav_reg ? S_LN0 : S_PASS;
			S_LN0: state_next = S_LN1;
			S_LN1: state_next = S_CRC0;
			S_CRC0: state_next = S_CRC1;
			S_CRC1: state_next = S_PASS;
			default: state_next = S_PASS;
		endcase
	end

	// state, latched flags and line count
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			state_reg <= S_PASS;
			is_eav_reg <= 1'b0;
			field_reg <= 1'b0;
			vblank_reg <= 1'b0;
			line_reg <= LINE_RST;
		end
		else if (fire)
		begin
			state_reg <= state_next;
			if (trs_start)
			begin
				is_eav_reg <= start_eav;
				field_reg <= VID_IN.field_bit;
				vblank_reg <= VID_IN.vblank_bit;
				if (start_eav)
					line_reg <= VID_IN.first_line ? LINE_FIRST : line_reg + 1'b1;
			end
		end
	end

	// crc region flag: opens after sav, closes after the second line number word
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
			in_active_reg <= 1'b0;
		else if (crc_clear)
			in_active_reg <= 1'b1;
		else if (fire && state_reg == S_LN1)
			in_active_reg <= 1'b0;
	end

	// two independent line crcs
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			crc_c_reg <= CRC_RST;
			crc_y_reg <= CRC_RST;
		end
		else if (crc_clear)
		begin
			crc_c_reg <= CRC_RST;
			crc_y_reg <= CRC_RST;
		end
		else if (crc_take)
		begin
			crc_c_reg <= crc_word(crc_c_reg, fmt_pair.c_word);
			crc_y_reg <= crc_word(crc_y_reg, fmt_pair.y_word);
		end
	end

	// =====================================================
	// buffer between formatter and encoder; chroma sits in the low word
	logic fifo_out_valid;
	logic [PAR_W-1:0] fifo_out_data;
	logic enc_pop;

	hst_fifo #(
		.WIDTH(PAR_W),
		.DEPTH(FIFO_DEPTH)
	) u_hst_fifo (
		.clk(SYS_CLK),
		.rst(RST),
		.in_valid(VID_VALID),
		.in_ready(fifo_in_ready),
		.in_data(fmt_pair),
		.out_valid(fifo_out_valid),
		.out_ready(TX_READY),
		.out_data(fifo_out_data)
	);

	assign enc_pop = fifo_out_valid && TX_READY;

	// =====================================================
	// parallel scrambler and nrzi, bit 0 is the first serial bit
	logic [8:0] scr_hist_reg;
	logic nrzi_last_reg;
	logic [28:0] scr_chain;
	logic [20:0] nrzi_chain;

	assign scr_chain[8:0] = scr_hist_reg;
	assign nrzi_chain[0] = nrzi_last_reg;

	genvar gi;
	generate
		for (gi = 0; gi < PAR_W; gi++)
		begin : g_enc
			// s[n] = d[n] ^ s[n-4] ^ s[n-9]
			assign scr_chain[gi+9] = fifo_out_data[gi] ^ scr_chain[gi+5] ^ scr_chain[gi];
			// o[n] = s[n] ^ o[n-1]
			assign nrzi_chain[gi+1] = scr_chain[gi+9] ^ nrzi_chain[gi];
		end
	endgenerate

	// encoder state and registered output
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			scr_hist_reg <= SCR_RST;
			nrzi_last_reg <= 1'b0;
			TX_DATA <= '0;
			TX_VALID <= 1'b0;
		end
		else if (TX_READY)
		begin
			TX_VALID <= fifo_out_valid;
			if (enc_pop)
			begin
				scr_hist_reg <= scr_chain[28:20];
				nrzi_last_reg <= nrzi_chain[20];
				TX_DATA <= nrzi_chain[20:1];
			end
		end
	end

	// =====================================================
	// checks
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	logic [LINE_W-1:0] line_prev_reg;
	logic [8:0] scr_out_reg;
	always_ff @(posedge SYS_CLK or posedge RST)
	begin
		if (RST)
		begin
			line_prev_reg <= LINE_RST;
			scr_out_reg <= SCR_RST;
		end
		else
		begin
			if (fire && state_reg == S_LN1)
				line_prev_reg <= line_reg;
			if (enc_pop)
				scr_out_reg <= scr_chain[28:20];
		end
	end

	sequence trs_head;
		fire && trs_start;
	endsequence

	sequence eav_flags;
		fire && state_reg == S_TRS3 && is_eav_reg;
	endsequence

	a_trs_first_word: assert property (trs_head |-> fmt_pair == {TRS_ONES, TRS_ONES})
		else $error("timing reference does not start with all ones");
	a_trs_zero_words: assert property (fire && (state_reg == S_TRS1 || state_reg == S_TRS2)
		|-> fmt_pair == '0)
		else $error("timing reference preamble zero words wrong");
	a_preamble_clip: assert property (fire && state_reg == S_PASS && !trs_start
		|-> fmt_pair.c_word != TRS_ONES && fmt_pair.y_word != TRS_ONES
		&& fmt_pair.c_word != TRS_ZERO && fmt_pair.y_word != TRS_ZERO)
		else $error("reserved code leaked into data words");
	a_flags_select: assert property (fire && state_reg == S_TRS3
		|-> fmt_pair.c_word[FLAG_H_POS] == is_eav_reg)
		else $error("eav/sav select bit wrong");
	a_ln_follows: assert property (eav_flags |=> state_reg == S_LN0)
		else $error("line number does not follow eav");
	a_ln_same: assert property (fire && (state_reg == S_LN0 || state_reg == S_LN1)
		|-> fmt_pair.c_word == fmt_pair.y_word)
		else $error("line number differs between channels");
	a_line_step: assert property (fire && state_reg == S_LN1 && line_reg != LINE_FIRST
		|-> line_reg == line_prev_reg + 1'b1)
		else $error("line number did not step by one");
	a_crc_clear: assert property (crc_clear |=> crc_c_reg == CRC_RST && crc_y_reg == CRC_RST
		&& in_active_reg)
		else $error("crc not cleared after sav");
	a_crc_split: assert property (fire && state_reg == S_CRC1
		|-> fmt_pair.y_word[8:0] == crc_y_reg[17:9]
		&& fmt_pair.y_word[9] == ~crc_y_reg[17])
		else $error("crc high word layout wrong");
	a_crc_hold: assert property (fire && state_reg == S_CRC0 |=> $stable(crc_y_reg))
		else $error("crc changed over its own words");
	a_nrzi_edge: assert property (enc_pop ##1 1'b1
		|-> (TX_DATA[19] ^ TX_DATA[18]) == scr_out_reg[8])
		else $error("nrzi output does not match scrambled bit");

endmodule : hst_tx_top

// >>> rtl/hst_pkg.sv
// shared types and constants for the hd link transmit formatter
package hst_pkg;

	// =====================================================
	// word widths and fixed words
	localparam int WORD_W = 10;
	localparam int LINE_W = 11;
	localparam int CRC_W = 18;
	localparam int PAR_W = 20;
	localparam int FIFO_DEPTH = 8;
	localparam logic [9:0] TRS_ONES = 10'h3FF;
	localparam logic [9:0] TRS_ZERO = 10'h000;
	localparam logic [9:0] CLIP_HI_LIM = 10'h3FC;
	localparam logic [9:0] CLIP_HI_VAL = 10'h3FB;
	localparam logic [9:0] CLIP_LO_LIM = 10'h003;
	localparam logic [9:0] CLIP_LO_VAL = 10'h004;

	// =====================================================
	// field positions inside the timing flags word
	localparam int FLAG_F_POS = 8;
	localparam int FLAG_V_POS = 7;
	localparam int FLAG_H_POS = 6;

	// =====================================================
	// reset values
	localparam logic [LINE_W-1:0] LINE_RST = 11'h000;
	localparam logic [LINE_W-1:0] LINE_FIRST = 11'h001;
	localparam logic [CRC_W-1:0] CRC_RST = 18'h0_0000;
	localparam logic [8:0] SCR_RST = 9'h000;

	// =====================================================
	// one sample of the two synchronous channels from the source
	typedef struct packed {
		logic [WORD_W-1:0] c_word;
		logic [WORD_W-1:0] y_word;
		logic eav_start;  // first of the 8 slots reserved for eav, line number and crc
		logic sav_start;  // first of the 4 slots reserved for sav
		logic field_bit;
		logic vblank_bit;
		logic first_line; // with eav_start: this line is numbered 1
	} hst_sample_t;

	// one formatted sample, chroma and luma
	typedef struct packed {
		logic [WORD_W-1:0] y_word;
		logic [WORD_W-1:0] c_word;
	} hst_pair_t;

	// formatter slot sequence
	typedef enum logic [2:0] {
		S_PASS, S_TRS1, S_TRS2, S_TRS3, S_LN0, S_LN1, S_CRC0, S_CRC1
	} hst_state_t;

endpackage : hst_pkg

// >>> rtl/hst_fifo.sv
// synchronous valid/ready fifo with parameter width and depth
`timescale 1ns/1ns
module hst_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_CNT = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	// honest full and empty from the occupancy count
	assign in_ready = (count_reg != DEPTH_CNT);
	assign out_valid = (count_reg != '0);
	assign out_data = mem[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// pointers and count
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == LAST_IDX) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == LAST_IDX) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule : hst_fifo

// >>> test/hst_ser_model.sv
// serializer model: takes encoded words and recovers the interleaved word stream
`timescale 1ns/1ns
module hst_ser_model
	import hst_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// encoded stream from the formatter
	input wire logic [PAR_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	// pacing: 0 prompt, 1 one edge in four, 2 stopped
	input wire logic [1:0] pace
);
	logic [PAR_W-1:0] rx_q[$];
	logic nrzi_prev_reg;
	logic [8:0] hist_reg;
	logic [1:0] cnt_reg;

	// =====================================================
	// take a word on each ready edge, undo nrzi then descramble bit by bit
	always @(posedge clk or posedge rst)
	begin : take
		logic t;
		logic s;
		logic np;
		logic [8:0] h;
		logic [PAR_W-1:0] w;
		if (rst)
		begin
			nrzi_prev_reg <= 1'b0;
			hist_reg <= 9'h000;
			cnt_reg <= 2'h0;
			tx_ready <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_reg + 2'h1;
			tx_ready <= (pace == 2'h0) || (pace == 2'h1 && cnt_reg == 2'h3);
			if (tx_ready && tx_valid)
			begin
				np = nrzi_prev_reg;
				h = hist_reg;
				for (int i = 0; i < PAR_W; i++)
				begin
					t = tx_data[i];
					s = t ^ np;
					np = t;
					w[i] = s ^ h[3] ^ h[8];
					h = {h[7:0], s};
				end
				nrzi_prev_reg <= np;
				hist_reg <= h;
				rx_q.push_back(w);
			end
		end
	end

endmodule : hst_ser_model

// >>> test/tb_top.sv
// self-checking bench for the hd link transmit formatter
`timescale 1ns/1ns
module tb_top
	import hst_pkg::*;
;
	logic SYS_CLK;
	logic RST;
	hst_sample_t VID_IN;
	logic VID_VALID;
	logic VID_READY;
	logic [PAR_W-1:0] TX_DATA;
	logic TX_VALID;
	logic TX_READY;
	logic [1:0] pace;
	int n_mismatch;
	int n_compared;
	int n_refuse;
	logic [PAR_W-1:0] exp_q[$];
	logic [LINE_W-1:0] ln_cur;
	logic [CRC_W-1:0] crc_y;
	logic [CRC_W-1:0] crc_c;
	logic crc_open;

	// =====================================================
	// design and serializer model
	hst_tx_top u_hst_tx_top (.SYS_CLK(SYS_CLK), .RST(RST), .VID_IN(VID_IN),
		.VID_VALID(VID_VALID), .VID_READY(VID_READY), .TX_DATA(TX_DATA),
		.TX_VALID(TX_VALID), .TX_READY(TX_READY));
	hst_ser_model u_hst_ser_model (.clk(SYS_CLK), .rst(RST), .tx_data(TX_DATA),
		.tx_valid(TX_VALID), .tx_ready(TX_READY), .pace(pace));

	always #4 SYS_CLK = ~SYS_CLK;

	// =====================================================
	// expected-value helpers
	function automatic logic [9:0] clip(input logic [9:0] w);
		return (w >= CLIP_HI_LIM) ? CLIP_HI_VAL : (w <= CLIP_LO_LIM) ? CLIP_LO_VAL : w;
	endfunction : clip

	function automatic logic [9:0] flg(input logic f, v, h);
		return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
	endfunction : flg

	function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic [9:0] d);
		logic fb;
		for (int i = 0; i < WORD_W; i++)
		begin
			fb = c[0] ^ d[i];
			c = (c >> 1) ^ (fb ? 18'h2_3000 : 18'h0_0000);
		end
		return c;
	endfunction : crc_step

	task automatic put(input logic [9:0] y, c);
		exp_q.push_back(hst_pair_t'{y_word: y, c_word: c});
	endtask : put

	// =====================================================
	// compare and closing
	task automatic cmp_word(input logic [PAR_W-1:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_word

	task automatic cmp_bit(input logic e, g);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp_bit

	task automatic report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : report_and_stop

	// =====================================================
	// source side: one sample offered at a falling edge, held until taken
	task automatic snd(input logic [9:0] c, y, input logic e, s, fl, f, v);
		int k;
		VID_IN = '{c_word: c, y_word: y, eav_start: e, sav_start: s, field_bit: f,
			vblank_bit: v, first_line: fl};
		VID_VALID = 1'b1;
		for (k = 0; k < 300 && VID_READY !== 1'b1; k++)
		begin
			n_refuse++;
			@(negedge SYS_CLK);
		end
		if (k == 300)
		begin
			n_mismatch++;
			report_and_stop();
		end
		@(negedge SYS_CLK);
	endtask : snd

	// one whole line: eav slots, blanking, sav slots, active; builds the expected stream
	task automatic send_line(input logic fl, f, v, input int nb, na, input logic [9:0] b);
		logic [9:0] w[8];
		logic [9:0] c;
		ln_cur = fl ? LINE_FIRST : ln_cur + 11'h001;
		w = '{TRS_ONES, TRS_ZERO, TRS_ZERO, flg(f, v, 1'b1), {~ln_cur[6], ln_cur[6:0], 2'b00},
			{4'h8, ln_cur[10:7], 2'b00}, TRS_ZERO, TRS_ZERO};
		for (int i = 0; i < 6 && crc_open; i++)
		begin
			crc_c = crc_step(crc_c, w[i]);
			crc_y = crc_step(crc_y, w[i]);
		end
		for (int i = 0; i < 8; i++)
		begin
			snd(b, b, i == 0, 1'b0, fl && i == 0, f, v);
			if (i == 6)
				put({~crc_y[8], crc_y[8:0]}, {~crc_c[8], crc_c[8:0]});
			else if (i == 7)
				put({~crc_y[17], crc_y[17:9]}, {~crc_c[17], crc_c[17:9]});
			else
				put(w[i], w[i]);
		end
		crc_open = 1'b0;
		for (int i = 0; i < nb; i++)
		begin
			c = b + 10'(2 * i);
			snd(c, c + 10'h001, 1'b0, 1'b0, 1'b0, f, v);
			put(clip(c + 10'h001), clip(c));
		end
		w[3] = flg(f, v, 1'b0);
		for (int i = 0; i < 4; i++)
		begin
			snd(b, b, 1'b0, i == 0, 1'b0, f, v);
			put(w[i], w[i]);
		end
		crc_c = CRC_RST;
		crc_y = CRC_RST;
		crc_open = 1'b1;
		for (int i = 0; i < na; i++)
		begin
			c = b + 10'(2 * i + 1);
			snd(c, c + 10'h001, 1'b0, 1'b0, 1'b0, f, v);
			put(clip(c + 10'h001), clip(c));
			crc_c = crc_step(crc_c, clip(c));
			crc_y = crc_step(crc_y, clip(c + 10'h001));
		end
	endtask : send_line

	// wait for the model to gather every expected word, then compare in order
	task automatic drain_check(input string name);
		int k;
		VID_VALID = 1'b0;
		for (k = 0; k < 500 && u_hst_ser_model.rx_q.size() < exp_q.size(); k++)
			@(negedge SYS_CLK);
		if (k == 500)
		begin
			n_mismatch++;
			report_and_stop();
		end
		while (exp_q.size() > 0)
			cmp_word(exp_q.pop_front(), u_hst_ser_model.rx_q.pop_front());
		$display("test %s done", name);
	endtask : drain_check

	// =====================================================
	// scenarios
	task automatic t_lines();
		send_line(1'b1, 1'b0, 1'b0, 3, 4, 10'h040);
		send_line(1'b0, 1'b1, 1'b1, 2, 5, 10'h3FC);
		send_line(1'b0, 1'b1, 1'b0, 2, 3, 10'h123);
		drain_check("lines");
	endtask : t_lines

	task automatic t_slow();
		pace = 2'h1;
		send_line(1'b0, 1'b0, 1'b0, 2, 6, 10'h2A0);
		drain_check("slow serializer");
		pace = 2'h0;
	endtask : t_slow

	task automatic t_full();
		pace = 2'h2;
		n_refuse = 0;
		fork
			send_line(1'b0, 1'b0, 1'b0, 4, 4, 10'h155);
			begin
				repeat (40) @(negedge SYS_CLK);
				cmp_bit(1'b0, VID_READY);
				pace = 2'h0;
			end
		join
		cmp_bit(1'b1, n_refuse > 0);
		drain_check("full fifo");
	endtask : t_full

	task automatic t_reset();
		pace = 2'h2;
		snd(10'h100, 10'h100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		snd(10'h101, 10'h102, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		VID_VALID = 1'b0;
		RST = 1'b1;
		@(negedge SYS_CLK);
		cmp_bit(1'b0, TX_VALID);
		cmp_bit(1'b1, VID_READY);
		repeat (2) @(negedge SYS_CLK);
		RST = 1'b0;
		pace = 2'h0;
		exp_q.delete();
		u_hst_ser_model.rx_q.delete();
		ln_cur = LINE_RST;
		crc_c = CRC_RST;
		crc_y = CRC_RST;
		crc_open = 1'b0;
		send_line(1'b0, 1'b0, 1'b0, 2, 3, 10'h0C0);
		drain_check("reset mid line");
	endtask : t_reset

	// =====================================================
	// main sequence
	initial
	begin
		SYS_CLK = 1'b0;
		RST = 1'b1;
		VID_IN = '0;
		VID_VALID = 1'b0;
		pace = 2'h0;
		n_mismatch = 0;
		n_compared = 0;
		n_refuse = 0;
		ln_cur = LINE_RST;
		crc_c = CRC_RST;
		crc_y = CRC_RST;
		crc_open = 1'b0;
		repeat (3) @(negedge SYS_CLK);
		RST = 1'b0;
		t_lines();
		t_slow();
		t_full();
		t_reset();
		report_and_stop();
	end

endmodule : tb_top
